// ==== dv/pbc_analog_model.sv ====
// behavioural analog loop and system integration side
`default_nettype none
module pbc_analog_model (
  // clock and bench requests
  input wire logic clk,
  input wire logic lock_req,
  input wire logic trk_req,
  input wire logic xtal_run,
  input wire logic osc_req,
  input wire logic brk_req,
  // loop enable from the block
  input wire logic pll_en,
  // levels toward the block
  output logic lock,
  output logic trk,
  output logic xtal_clk,
  output logic vco_clk,
  output logic osc_en,
  output logic brk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] xdiv = 2'h0; // crystal divider, period four clocks
  logic [1:0] vdiv = 2'h0; // vco divider, period six clocks
  logic vco_q = 1'b0;
  logic lock_q = 1'b0;
  logic trk_q = 1'b0;
  // crystal stands still when lost or stopped
  always @(posedge clk) begin
    if (xtal_run && osc_req) begin
      xdiv <= xdiv + 2'h1;
    end
  end
  // vco runs only while the loop is enabled
  always @(posedge clk) begin
    if (pll_en) begin
      vdiv <= (vdiv == 2'h2) ? 2'h0 : vdiv + 2'h1;
      if (vdiv == 2'h2) begin
        vco_q <= ~vco_q;
      end
    end
  end
  // loop status follows requests a clock late, lost when disabled
  always @(posedge clk) begin
    lock_q <= lock_req & pll_en;
    trk_q <= trk_req & pll_en;
  end
  assign lock = lock_q;
  assign trk = trk_q;
  assign xtal_clk = xdiv[1];
  assign vco_clk = vco_q;
  assign osc_en = osc_req;
  assign brk = brk_req;
endmodule
`default_nettype wire

// ==== dv/pbc_ctrl_monitor.sv ====
// port assertions for the pll bandwidth and programming block
`default_nettype none
module pbc_ctrl_monitor
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // bus handshakes
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic BVALID,
  input wire logic BREADY,
  // generator side
  input wire logic OSC_ENABLE_IN,
  input wire logic PLL_ENABLE_OUT,
  input wire logic [3:0] FEEDBACK_RATIO_N_OUT,
  input wire logic [3:0] VCO_RANGE_OUT,
  input wire logic CRYSTAL_CLOCK_OUT,
  input wire logic BASE_CLOCK_OUT,
  input wire logic PLL_IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // stop silences irq, base clock, crystal clock and pll enable one edge later
  a_stop_quiets: assert property (!OSC_ENABLE_IN |=>
    !(PLL_IRQ_OUT || BASE_CLOCK_OUT || CRYSTAL_CLOCK_OUT || PLL_ENABLE_OUT))
    else $error("generator output active during stop");
  a_irq_needs_osc: assert property (PLL_IRQ_OUT |-> $past(OSC_ENABLE_IN))
    else $error("irq raised without oscillator");
  a_ratio_nonzero: assert property (FEEDBACK_RATIO_N_OUT != 4'h0)
    else $error("feedback ratio of zero");
  // programming is frozen while the loop is enabled
  a_prog_frozen: assert property (PLL_ENABLE_OUT |=>
    $stable(FEEDBACK_RATIO_N_OUT) && $stable(VCO_RANGE_OUT))
    else $error("programming changed while pll on");
  a_range_zero_off: assert property (VCO_RANGE_OUT == 4'h0 |-> !PLL_ENABLE_OUT)
    else $error("pll enabled with zero range");
  // read answers on the handshake edge, ready returns two edges after
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read not answered");
  a_read_single: assert property (RVALID && RREADY |=> !RVALID && !ARREADY ##1 ARREADY)
    else $error("read channel not recovered");
  a_write_single: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response held after handshake");
  a_rdata_byte: assert property (RVALID |-> RDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule
`default_nettype wire

// ==== dv/tb_pll_bandwidth_and_program_ctrl.sv ====
// self-checking bench for the pll bandwidth and programming block
`include "pbc_defines.svh"
`default_nettype none
module tb_pll_bandwidth_and_program_ctrl
  import pbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // register byte addresses
  localparam logic [11:0] A_CTRL = {2'h0, `PBC_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_BW = {2'h0, `PBC_IDX_BW, 2'h0};
  localparam logic [11:0] A_PROG = {2'h0, `PBC_IDX_PROG, 2'h0};
  localparam logic [11:0] A_BRK = {2'h0, `PBC_IDX_BRK, 2'h0};
  // bench drive
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [11:0] AWADDR = 12'h000;
  logic [11:0] ARADDR = 12'h000;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic lock_req = 1'b0, trk_req = 1'b0, xtal_run = 1'b1, osc_req = 1'b1, brk_req = 1'b0;
  // design answers and partner levels
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  logic lock_w, trk_w, xtal_w, vco_w, osc_w, brk_w;
  logic PLL_ENABLE_OUT, AUTO_MODE_OUT, FORCE_TRACKING_OUT;
  logic CRYSTAL_CLOCK_OUT, BASE_CLOCK_OUT, PLL_IRQ_OUT;
  logic [3:0] FEEDBACK_RATIO_N_OUT, VCO_RANGE_OUT;
  // scoreboard
  int bad_count = 0;
  int tests_run = 0;
  logic [1:0] last_resp;
  logic [31:0] seed = 32'h0D230676;

  always #10 CLK = ~CLK;

  pbc_ctrl pbc_ctrl_inst (.CLK(CLK), .RSTN(RSTN), .CE(1'b1), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .PLL_LOCK_IN(lock_w), .PLL_TRACKING_IN(trk_w),
    .CRYSTAL_CLOCK_IN(xtal_w), .VCO_CLOCK_IN(vco_w), .OSC_ENABLE_IN(osc_w),
    .BREAK_ACTIVE(brk_w), .PLL_ENABLE_OUT(PLL_ENABLE_OUT), .AUTO_MODE_OUT(AUTO_MODE_OUT),
    .FORCE_TRACKING_OUT(FORCE_TRACKING_OUT), .FEEDBACK_RATIO_N_OUT(FEEDBACK_RATIO_N_OUT),
    .VCO_RANGE_OUT(VCO_RANGE_OUT), .CRYSTAL_CLOCK_OUT(CRYSTAL_CLOCK_OUT),
    .BASE_CLOCK_OUT(BASE_CLOCK_OUT), .PLL_IRQ_OUT(PLL_IRQ_OUT));

  pbc_analog_model pbc_analog_model_inst (.clk(CLK), .lock_req(lock_req),
    .trk_req(trk_req), .xtal_run(xtal_run), .osc_req(osc_req), .brk_req(brk_req),
    .pll_en(PLL_ENABLE_OUT), .lock(lock_w), .trk(trk_w), .xtal_clk(xtal_w),
    .vco_clk(vco_w), .osc_en(osc_w), .brk(brk_w));

  // pseudo-random step
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // code zero multiplies like code one
  function automatic logic [3:0] exp_n(input logic [3:0] m);
    return (m == 4'h0) ? 4'h1 : m;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // write one byte, both halves offered together, bready held till the answer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      n++;
    end while (!BVALID && n < 50);
    BREADY <= 1'b0;
    last_resp = BRESP;
    if (n >= 50) chk("write answer", 1, 0);
    if (n >= 50) test_done();
  endtask

  // read one register and compare the whole data word
  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string what);
    int n;
    n = 0;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      n++;
    end while (!RVALID && n < 50);
    RREADY <= 1'b0;
    last_resp = RRESP;
    if (n >= 50) chk("read answer", 1, 0);
    if (n >= 50) test_done();
    chk(what, {24'h0, e}, RDATA);
  endtask

  // count base clock rises over 96 clocks, one either way allowed
  task automatic base_rate(input int e);
    int c;
    logic p;
    c = 0;
    p = BASE_CLOCK_OUT;
    repeat (96) begin
      @(posedge CLK);
      if (BASE_CLOCK_OUT && !p) c++;
      p = BASE_CLOCK_OUT;
    end
    chk("base clock rises", e, (c >= e - 1 && c <= e + 1) ? e : c);
  endtask

  // main sequence
  initial begin
    logic [7:0] v;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (2) @(posedge CLK);
    rdc(A_CTRL, 8'h2F, "ctrl reset");
    rdc(A_BW, 8'h00, "bw reset");
    rdc(A_PROG, 8'h66, "prog reset");
    chk("ratio reset", 4'h6, FEEDBACK_RATIO_N_OUT);
    chk("range reset", 4'h6, VCO_RANGE_OUT);
    seed = lfsr(seed);
    wr(A_PROG, seed[7:0]);
    rdc(A_PROG, 8'h66, "prog locked");
    wr(A_CTRL, 8'h00);
    rdc(A_CTRL, 8'h0F, "pll off");
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      v = {i[3:0], seed[3:0] | 4'h1};
      wr(A_PROG, v);
      rdc(A_PROG, v, "prog field");
      chk("ratio", exp_n(i[3:0]), FEEDBACK_RATIO_N_OUT);
    end
    $display("test programming done");
    wr(A_PROG, 8'h60);
    wr(A_CTRL, 8'h20);
    wr(A_CTRL, 8'h30);
    rdc(A_CTRL, 8'h2F, "select blocked");
    chk("enable zero range", 0, PLL_ENABLE_OUT);
    wr(A_CTRL, 8'h00);
    wr(A_PROG, 8'h66);
    wr(A_CTRL, 8'h20);
    wr(A_CTRL, 8'h30);
    rdc(A_CTRL, 8'h3F, "vco selected");
    base_rate(8);
    $display("test range done");
    wr(A_BW, 8'h20);
    @(posedge CLK);
    chk("force tracking", 1, FORCE_TRACKING_OUT);
    rdc(A_BW, 8'h20, "manual tracking");
    wr(A_BW, 8'hA0);
    rdc(A_BW, 8'h80, "auto acquiring");
    chk("auto out", 1, AUTO_MODE_OUT);
    lock_req <= 1'b1;
    trk_req <= 1'b1;
    repeat (8) @(posedge CLK);
    rdc(A_BW, 8'hE0, "auto locked");
    wr(A_CTRL, 8'hB0);
    repeat (2) @(posedge CLK);
    chk("irq enabled", 1, PLL_IRQ_OUT);
    rdc(A_CTRL, 8'hFF, "flag set");
    rdc(A_CTRL, 8'hBF, "flag cleared");
    chk("irq cleared", 0, PLL_IRQ_OUT);
    brk_req <= 1'b1;
    lock_req <= 1'b0;
    repeat (8) @(posedge CLK);
    rdc(A_CTRL, 8'hFF, "flag in break");
    rdc(A_CTRL, 8'hFF, "flag kept in break");
    wr(A_BRK, 8'h01);
    rdc(A_CTRL, 8'hFF, "flag read in break");
    rdc(A_CTRL, 8'hBF, "flag cleared in break");
    wr(A_BRK, 8'h00);
    brk_req <= 1'b0;
    rdc(A_CTRL, 8'hBF, "flag after break");
    wr(A_CTRL, 8'h30);
    lock_req <= 1'b1;
    repeat (8) @(posedge CLK);
    chk("irq masked", 0, PLL_IRQ_OUT);
    rdc(A_CTRL, 8'h7F, "flag unmasked");
    wr(A_BW, 8'h00);
    rdc(A_BW, 8'h20, "tracking restored");
    lock_req <= 1'b0;
    repeat (8) @(posedge CLK);
    rdc(A_CTRL, 8'h3F, "flag hidden manual");
    chk("irq manual", 0, PLL_IRQ_OUT);
    $display("test modes done");
    xtal_run <= 1'b0;
    wr(A_BW, 8'h30);
    repeat (4 * 6 * 4) @(posedge CLK);
    rdc(A_BW, 8'h30, "crystal lost");
    xtal_run <= 1'b1;
    wr(A_BW, 8'h30);
    repeat (4 * 6 * 4) @(posedge CLK);
    rdc(A_BW, 8'h20, "crystal present");
    osc_req <= 1'b0;
    repeat (4) @(posedge CLK);
    chk("base in stop", 0, BASE_CLOCK_OUT);
    chk("crystal in stop", 0, CRYSTAL_CLOCK_OUT);
    osc_req <= 1'b1;
    repeat (4) @(posedge CLK);
    rdc(A_CTRL, 8'h2F, "select after stop");
    base_rate(12);
    wr(12'h000, 8'hFF);
    chk("unmapped write", `PBC_RESP_DECERR, last_resp);
    rdc(12'h004, 8'h00, "unmapped read");
    chk("unmapped read resp", `PBC_RESP_DECERR, last_resp);
    $display("test stop done");
    test_done();
  end
endmodule

bind pbc_ctrl pbc_ctrl_monitor pbc_ctrl_monitor_inst (.CLK(CLK), .RSTN(RSTN),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
  .BVALID(BVALID), .BREADY(BREADY), .OSC_ENABLE_IN(OSC_ENABLE_IN),
  .PLL_ENABLE_OUT(PLL_ENABLE_OUT), .FEEDBACK_RATIO_N_OUT(FEEDBACK_RATIO_N_OUT),
  .VCO_RANGE_OUT(VCO_RANGE_OUT), .CRYSTAL_CLOCK_OUT(CRYSTAL_CLOCK_OUT),
  .BASE_CLOCK_OUT(BASE_CLOCK_OUT), .PLL_IRQ_OUT(PLL_IRQ_OUT));
`default_nettype wire

// ==== verilog/pbc_ctrl.sv ====
// pll bandwidth, programming and control registers behind an axi4-lite slave
//
// Overview of operation
// - auto bit selects bandwidth mode, reset manual
// - lock bit shows lock only in auto
// - auto mode: tracking bit reflects loop state
// - manual mode: tracking bit forces loop mode
// - manual tracking value kept across auto mode
// - loss bit shows crystal absence, vco only
// - multiplier code zero acts as one
// - multiplier resets to six
// - multiplier writes ignored while pll on
// - vco range rw, locked while on, resets six
// - zero range disables pll, blocks vco select
// - lock change sets flag; irq needs enable
// - manual mode: no irq, flag reads zero
// - wait state leaves generator untouched
// - oscillator enable low holds pll enable, irq and clocks low
// - stop clears base select, crystal drives
// - break protects flag unless clear enabled
// - control register read clears event flag
// - base clock is selected source halved
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "pbc_defines.svh"
`default_nettype none
module pbc_ctrl
  import pbc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock, reset, clock enable
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // axi4-lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // axi4-lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // analog loop status
  input wire logic PLL_LOCK_IN,
  input wire logic PLL_TRACKING_IN,
  // clock sources, sampled as levels
  input wire logic CRYSTAL_CLOCK_IN,
  input wire logic VCO_CLOCK_IN,
  // system integration unit
  input wire logic OSC_ENABLE_IN,
  input wire logic BREAK_ACTIVE,
  // analog loop control
  output logic PLL_ENABLE_OUT,
  output logic AUTO_MODE_OUT,
  output logic FORCE_TRACKING_OUT,
  output logic [3:0] FEEDBACK_RATIO_N_OUT,
  output logic [3:0] VCO_RANGE_OUT,
  // clocks and interrupt
  output logic CRYSTAL_CLOCK_OUT,
  output logic BASE_CLOCK_OUT,
  output logic PLL_IRQ_OUT
);

  // =====================================================================
  // declarations
  logic [ADDR_W-1:0] aw_addr_reg; // captured write address
  logic [7:0] w_data_reg; // captured low data byte
  logic aw_have_reg, w_have_reg, w_strb_reg; // halves held, low lane strobe
  logic do_write, wr_hit, rd_hit, rd_take; // write go, decode hits, read handshake
  logic [7:0] wr_idx, rd_idx; // write and read register indices
  logic wr_ctrl, wr_bw, wr_prog, wr_brk; // register write strobes
  logic ie_reg, flag_reg, pll_power_on_reg, bcs_reg; // control register bits
  logic auto_reg, trk_manual_reg, xld_reg; // auto mode, manual tracking, loss latch
  pbc_nibble_type mul_reg, vrs_reg; // feedback ratio and vco range fields
  logic break_flag_clear_en_reg; // break flag clear enable
  logic [2:0] sync_q; // synchronised lock, tracking, crystal
  logic lock_s, trk_s, xtal_s; // synchronised levels
  logic lock_prev_reg, xtal_prev_reg, vco_prev_reg; // last-cycle levels for edges
  logic lock_change, flag_clear; // lock toggled in auto, flag clearing read
  logic vrs_zero, src_rise; // range zero, selected source rising
  pbc_byte_type rd_byte; // read mux result
  logic [ADDR_W-1:0] idx_limit; // lowest address past the indexed range
  initial begin
    if (ADDR_W < 11) begin
      $error("pbc_ctrl: ADDR_W must be at least 11");
    end
  end
  // =====================================================================
  // analog status synchroniser
  pbc_sync #(.WIDTH(3)) u_sync (
    .clk(CLK), .rst_n(RSTN), .ce(CE),
    .d({PLL_LOCK_IN, PLL_TRACKING_IN, CRYSTAL_CLOCK_IN}),
    .q(sync_q)
  );
  // lock, tracking and crystal reach the status bits only after two flops
  assign lock_s = sync_q[2];
  assign trk_s = sync_q[1];
  assign xtal_s = sync_q[0];
  // =====================================================================
  // address decode
  assign idx_limit = ADDR_W'(1024);
  assign wr_idx = aw_addr_reg[9:2];
  assign rd_idx = ARADDR[9:2];
  // an index hits only with zero upper bits and a known register
  assign wr_hit = (aw_addr_reg < idx_limit) &&
    (wr_idx >= `PBC_IDX_CTRL) && (wr_idx <= `PBC_IDX_BRK);
  assign rd_hit = (ARADDR < idx_limit) &&
    (rd_idx >= `PBC_IDX_CTRL) && (rd_idx <= `PBC_IDX_BRK);
  assign do_write = aw_have_reg && w_have_reg && !BVALID;
  assign rd_take = ARVALID && ARREADY;
  // only the low byte lane carries register data
  assign wr_ctrl = do_write && wr_hit && w_strb_reg && (wr_idx == `PBC_IDX_CTRL);
  assign wr_bw = do_write && wr_hit && w_strb_reg && (wr_idx == `PBC_IDX_BW);
  assign wr_prog = do_write && wr_hit && w_strb_reg && (wr_idx == `PBC_IDX_PROG);
  assign wr_brk = do_write && wr_hit && w_strb_reg && (wr_idx == `PBC_IDX_BRK);
  // =====================================================================
  // write channel: address and data taken in either order
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_addr_reg <= '0;
      aw_have_reg <= 1'b0;
      AWREADY <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      w_have_reg <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `PBC_RESP_OKAY;
    end else if (CE) begin
      // address half
      if (AWVALID && AWREADY) begin
        aw_addr_reg <= AWADDR;
        aw_have_reg <= 1'b1;
        AWREADY <= 1'b0;
      end else if (!aw_have_reg && !BVALID) begin
        AWREADY <= 1'b1;
      end
      // data half
      if (WVALID && WREADY) begin
        w_data_reg <= WDATA[7:0];
        w_strb_reg <= WSTRB[0];
        w_have_reg <= 1'b1;
        WREADY <= 1'b0;
      end else if (!w_have_reg && !BVALID) begin
        WREADY <= 1'b1;
      end
      // response after both halves
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_hit ? `PBC_RESP_OKAY : `PBC_RESP_DECERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end
  // =====================================================================
  // read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      `PBC_IDX_CTRL: begin
        rd_byte[`PBC_CTRL_IE] = ie_reg;
        rd_byte[`PBC_CTRL_EF] = flag_reg && auto_reg;
        rd_byte[`PBC_CTRL_ON] = pll_power_on_reg;
        rd_byte[`PBC_CTRL_BCS] = bcs_reg;
        rd_byte[3:0] = `PBC_CTRL_FILL;
      end
      `PBC_IDX_BW: begin
        rd_byte[`PBC_BW_AUTO] = auto_reg;
        rd_byte[`PBC_BW_LOCK] = auto_reg && lock_s;
        // loop state in auto, stored manual value otherwise
        rd_byte[`PBC_BW_TRK] = auto_reg ? trk_s : trk_manual_reg;
        rd_byte[`PBC_BW_XLD] = xld_reg && bcs_reg;
      end
      `PBC_IDX_PROG: begin
        rd_byte[7:4] = mul_reg;
        rd_byte[3:0] = vrs_reg;
      end
      `PBC_IDX_BRK: rd_byte[`PBC_BRK_BREAK_FLAG_CLEAR_EN] = break_flag_clear_en_reg;
      default: rd_byte = 8'h00;
    endcase
  end
  // =====================================================================
  // read channel: one cycle from address handshake to data
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= `PBC_RESP_OKAY;
    end else if (CE) begin
      if (rd_take) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RDATA <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        RRESP <= rd_hit ? `PBC_RESP_OKAY : `PBC_RESP_DECERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end else if (!RVALID) begin
        ARREADY <= 1'b1;
      end
    end
  end
  // =====================================================================
  // bandwidth mode and tracking select
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      auto_reg <= 1'b0;
      trk_manual_reg <= 1'b0;
    end else if (CE && wr_bw) begin
      auto_reg <= w_data_reg[`PBC_BW_AUTO];
      // tracking select writable only in manual mode; held through auto
      if (!auto_reg) begin
        trk_manual_reg <= w_data_reg[`PBC_BW_TRK];
      end
    end
  end
  // =====================================================================
  // crystal loss latch: write one arms, a crystal edge clears
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      xld_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
    end else if (CE) begin
      xtal_prev_reg <= xtal_s;
      // the arming write wins over a crystal edge in the same cycle
      if (wr_bw && w_data_reg[`PBC_BW_XLD]) begin
        xld_reg <= 1'b1;
      end else if (xtal_s && !xtal_prev_reg) begin
        xld_reg <= 1'b0;
      end
    end
  end
  // =====================================================================
  // programming register, frozen while the pll is on
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mul_reg <= `PBC_MUL_RST;
      vrs_reg <= `PBC_VRS_RST;
    end else if (CE && wr_prog && !pll_power_on_reg) begin
      mul_reg <= w_data_reg[`PBC_PROG_MUL_LSB +: 4];
      vrs_reg <= w_data_reg[`PBC_PROG_VRS_LSB +: 4];
    end
  end
  assign vrs_zero = (vrs_reg == 4'h0);
  // =====================================================================
  // break flag clear enable
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      break_flag_clear_en_reg <= 1'b0;
    end else if (CE && wr_brk) begin
      break_flag_clear_en_reg <= w_data_reg[`PBC_BRK_BREAK_FLAG_CLEAR_EN];
    end
  end
  // =====================================================================
  // control register: enable, power on, base select
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ie_reg <= 1'b0;
      pll_power_on_reg <= 1'b1;
      bcs_reg <= 1'b0;
    end else if (CE) begin
      // enable only writable in auto mode, forced low in manual
      if (!auto_reg) begin
        ie_reg <= 1'b0;
      end else if (wr_ctrl) begin
        ie_reg <= w_data_reg[`PBC_CTRL_IE];
      end
      // power cannot drop while the vco drives the base clock
      if (wr_ctrl && !bcs_reg) begin
        pll_power_on_reg <= w_data_reg[`PBC_CTRL_ON];
      end
      // stop or zero range drops the vco select
      if (!OSC_ENABLE_IN) begin
        bcs_reg <= 1'b0;
      end else if (vrs_zero || !pll_power_on_reg) begin
        bcs_reg <= 1'b0;
      end else if (wr_ctrl) begin
        bcs_reg <= w_data_reg[`PBC_CTRL_BCS];
      end
    end
  end
  // =====================================================================
  // lock change event flag
  assign lock_change = auto_reg && (lock_s != lock_prev_reg);
  // reads clear the flag except during a protected break
  assign flag_clear = rd_take && rd_hit && (rd_idx == `PBC_IDX_CTRL) &&
    (!BREAK_ACTIVE || break_flag_clear_en_reg);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lock_prev_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else if (CE) begin
      lock_prev_reg <= lock_s;
      // a new lock change wins over a clearing read
      if (lock_change) begin
        flag_reg <= 1'b1;
      end else if (flag_clear) begin
        flag_reg <= 1'b0;
      end
    end
  end
  // =====================================================================
  // base clock: selected source halved, held low in stop
  assign src_rise = bcs_reg ? (VCO_CLOCK_IN && !vco_prev_reg) :
    (xtal_s && !xtal_prev_reg);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      vco_prev_reg <= 1'b0;
      BASE_CLOCK_OUT <= 1'b0;
      CRYSTAL_CLOCK_OUT <= 1'b0;
    end else if (CE) begin
      vco_prev_reg <= VCO_CLOCK_IN;
      // nothing here looks at wait, so wait leaves the clocks running
      if (!OSC_ENABLE_IN) begin
        BASE_CLOCK_OUT <= 1'b0;
        CRYSTAL_CLOCK_OUT <= 1'b0;
      end else begin
        if (src_rise) begin
          BASE_CLOCK_OUT <= !BASE_CLOCK_OUT;
        end
        CRYSTAL_CLOCK_OUT <= xtal_s;
      end
    end
  end
  // =====================================================================
  // analog loop controls and interrupt
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PLL_ENABLE_OUT <= 1'b0;
      AUTO_MODE_OUT <= 1'b0;
      FORCE_TRACKING_OUT <= 1'b0;
      FEEDBACK_RATIO_N_OUT <= `PBC_MUL_ONE;
      VCO_RANGE_OUT <= `PBC_VRS_RST;
      PLL_IRQ_OUT <= 1'b0;
    end else if (CE) begin
      // loop runs only when powered, ranged and oscillator enabled
      PLL_ENABLE_OUT <= pll_power_on_reg && !vrs_zero && OSC_ENABLE_IN;
      AUTO_MODE_OUT <= auto_reg;
      FORCE_TRACKING_OUT <= trk_manual_reg;
      // code zero divides as code one
      FEEDBACK_RATIO_N_OUT <= (mul_reg == `PBC_MUL_ZERO) ? `PBC_MUL_ONE : mul_reg;
      VCO_RANGE_OUT <= vrs_reg;
      // request only in auto mode with enable set and oscillator on
      PLL_IRQ_OUT <= OSC_ENABLE_IN && auto_reg && ie_reg && flag_reg;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/pbc_defines.svh ====
// register indices, field positions and reset values of the pll bandwidth/program block
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define PBC_IDX_CTRL 8'h1C
`define PBC_IDX_BW 8'h1D
`define PBC_IDX_PROG 8'h1E
`define PBC_IDX_BRK 8'h1F

// =====================================================================
// control register fields
`define PBC_CTRL_IE 7
`define PBC_CTRL_EF 6
`define PBC_CTRL_ON 5
`define PBC_CTRL_BCS 4
`define PBC_CTRL_FILL 4'hF

// =====================================================================
// bandwidth register fields
`define PBC_BW_AUTO 7
`define PBC_BW_LOCK 6
`define PBC_BW_TRK 5
`define PBC_BW_XLD 4

// =====================================================================
// programming register fields and reset values
`define PBC_PROG_MUL_LSB 4
`define PBC_PROG_VRS_LSB 0
`define PBC_MUL_RST 4'h6
`define PBC_VRS_RST 4'h6
`define PBC_MUL_ZERO 4'h0
`define PBC_MUL_ONE 4'h1

// =====================================================================
// break flag control register field
`define PBC_BRK_BREAK_FLAG_CLEAR_EN 0

// =====================================================================
// axi response codes
`define PBC_RESP_OKAY 2'h0
`define PBC_RESP_DECERR 2'h3

`endif

// ==== verilog/pbc_pkg.sv ====
// shared types of the pll bandwidth/program block
`default_nettype none
package pbc_pkg;
  // four-bit register field
  typedef logic [3:0] pbc_nibble_type;
  // register byte as seen by software
  typedef logic [7:0] pbc_byte_type;
endpackage
`default_nettype wire

// ==== verilog/pbc_sync.sv ====
// two-flop synchroniser for analog loop status levels
`default_nettype none
module pbc_sync
  import pbc_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // levels in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg; // first stage, read only by q

  initial begin
    if (WIDTH < 1) begin
      $error("pbc_sync: WIDTH must be at least 1");
    end
  end

  // =====================================================================
  // two stages, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire
